// ---- design/rsc_pkg.sv ----
// Purpose: constants for the reset source control block
// Assumes: 8-bit register port, 40 MHz system clock
// Notes: timing figures in ns, cycle counts derived below
package rsc_pkg;
   // ****************************************
   // register indices
   // ****************************************
   localparam logic [1:0] ADDR_PIN_SELECT = 2'h0;
   localparam logic [1:0] ADDR_CAUSE_FLAGS = 2'h1;
   localparam logic [1:0] ADDR_THRESHOLD = 2'h2;

   // ****************************************
   // codes and reset values
   // ****************************************
   localparam logic [7:0] PIN_SEL_IO = 8'h55;
   localparam logic [7:0] PIN_SEL_EXT_RESET = 8'hAA;
   localparam logic [7:0] THR_1V7 = 8'h66;
   localparam logic [7:0] THR_1V9 = 8'h55;
   localparam logic [7:0] THR_2V55 = 8'h33;
   localparam logic [7:0] THR_3V15 = 8'h99;
   localparam logic [7:0] THR_3V8 = 8'hAA;
   localparam logic [7:0] THR_DISABLE = 8'hF0;
   localparam logic [7:0] PIN_SEL_POR = PIN_SEL_IO;
   localparam logic [7:0] THR_POR = THR_1V7;

   // ****************************************
   // flag bit positions
   // ****************************************
   localparam int FLAG_SELECT_REG = 3;
   localparam int FLAG_LOW_SUPPLY = 2;
   localparam int FLAG_THRESHOLD_REG = 1;
   localparam int FLAG_WATCHDOG_REG = 0;
   localparam int FLAG_BITS = 4;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int SOFT_RESET_DELAY_NS = 1000;
   localparam int RESET_DELAY_TIME_NS = 2000;
   localparam int LOW_SUPPLY_FILTER_NS = 500;
   localparam int SOFT_RESET_CYC =
      (SOFT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_DELAY_CYC =
      (RESET_DELAY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_SUPPLY_CYC =
      (LOW_SUPPLY_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ****************************************
   // sequencer states, gray except between run and delay
   // ****************************************
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_HOLD = 2'b01,
      ST_DELAY = 2'b11
   } rsc_state_type;
endpackage : rsc_pkg

// ---- design/rsc_reset_source_control.sv ----
// Purpose: reset source selection, traps and cause flags
// Assumes: pins arrive asynchronous and are synchronised here
// Notes: one clock, one register port, no interrupts
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - power-on resets core and presets ports high
// - 0x55 selects I/O, 0xAA external reset
// - illegal pin select resets after soft delay
// - pin select powers up as 0x55
// - pin select trap sets bit 3 flag
// - all resets restore pin select, except warm watchdog restart
// - external reset selection overrides pin sharing
// - low external pin resets, restart at zero
// - hold while pin low, then reset delay
// - select flag set by hardware, software clears
// - flags at bits 3..0, upper bits zero
// - low supply detect off in sleep, idle
// - low supply must outlast filter time
// - threshold codes decode five levels, disable
// - illegal threshold resets, flags, restores register
// - genuine low supply keeps threshold register
// - threshold powers up as 0x66
// - watchdog flag set by hardware, software clears
module rsc_reset_source_control #(
   parameter int SOFT_RESET_CYCLES = rsc_pkg::SOFT_RESET_CYC,
   parameter int RESET_DELAY_CYCLES = rsc_pkg::RESET_DELAY_CYC,
   parameter int LOW_SUPPLY_CYCLES = rsc_pkg::LOW_SUPPLY_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // register port
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [7:0] regRdData_ff,
   // pins and monitors
   input wire logic resetPinN,
   input wire logic lowSupply,
   input wire logic sleepOrIdle,
   input wire logic watchdogRegTrap,
   input wire logic watchdogWarmReset,
   // core side
   output logic coreReset_ff,
   output logic pinIsReset_ff,
   output logic [2:0] thresholdLevel_ff,
   output logic lowSupplyEnable_ff
);
   // ****************************************
   // parameter checks
   // ****************************************
   localparam int CW = 16;
   localparam int CNT_MAX = 2**CW - 1;
   // counters are CW bits; longer delays need a wider CW
   if (SOFT_RESET_CYCLES < 1 ||
       SOFT_RESET_CYCLES > CNT_MAX) begin : g_bad_soft
      $error("rsc: soft reset count out of range");
   end
   if (RESET_DELAY_CYCLES < 1 ||
       RESET_DELAY_CYCLES > CNT_MAX) begin : g_bad_delay
      $error("rsc: reset delay count out of range");
   end
   if (LOW_SUPPLY_CYCLES < 1 ||
       LOW_SUPPLY_CYCLES > CNT_MAX) begin : g_bad_low
      $error("rsc: low supply count out of range");
   end

   localparam logic [CW-1:0] SOFT_LAST = CW'(SOFT_RESET_CYCLES - 1);
   localparam logic [CW-1:0] DELAY_LAST = CW'(RESET_DELAY_CYCLES - 1);
   localparam logic [CW-1:0] LOW_LAST = CW'(LOW_SUPPLY_CYCLES - 1);

   // ****************************************
   // input synchronisers
   // ****************************************
   logic [2:0] syncA_ff;
   logic [2:0] syncB_ff;
   logic pinN;
   logic lowSup;
   logic sleeping;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         syncA_ff <= 3'h7;
         syncB_ff <= 3'h7;
      end else begin
         syncA_ff <= {resetPinN, lowSupply, sleepOrIdle};
         syncB_ff <= syncA_ff;
      end
   end
   assign pinN = syncB_ff[2];
   assign lowSup = syncB_ff[1];
   assign sleeping = syncB_ff[0];

   // ****************************************
   // registers and decode
   // ****************************************
   logic [7:0] pinSelect_ff;
   logic [7:0] threshold_ff;
   logic [rsc_pkg::FLAG_BITS-1:0] flags_ff;
   logic pinSelLegal;
   logic thrLegal;
   logic thrEnabled;
   logic [2:0] nxt_level;
   logic extResetSel;

   assign pinSelLegal = (pinSelect_ff == rsc_pkg::PIN_SEL_IO) ||
      (pinSelect_ff == rsc_pkg::PIN_SEL_EXT_RESET);
   assign extResetSel = pinSelect_ff == rsc_pkg::PIN_SEL_EXT_RESET;

   always_comb begin
      thrLegal = 1'b1;
      thrEnabled = 1'b1;
      nxt_level = 3'h0;
      case (threshold_ff)
         rsc_pkg::THR_1V7: nxt_level = 3'h1;
         rsc_pkg::THR_1V9: nxt_level = 3'h2;
         rsc_pkg::THR_2V55: nxt_level = 3'h3;
         rsc_pkg::THR_3V15: nxt_level = 3'h4;
         rsc_pkg::THR_3V8: nxt_level = 3'h5;
         rsc_pkg::THR_DISABLE: thrEnabled = 1'b0;
         default: begin
            thrLegal = 1'b0;
            thrEnabled = 1'b0;
         end
      endcase
   end

   // ****************************************
   // trap and filter timers
   // ****************************************
   logic [CW-1:0] pinTrapCnt_ff;
   logic [CW-1:0] thrTrapCnt_ff;
   logic [CW-1:0] lowCnt_ff;
   logic pinTrapFire;
   logic thrTrapFire;
   logic lowFire;
   logic detectOn;
   logic busy;

   // detector idles in sleep or idle mode
   assign detectOn = thrEnabled && !sleeping;
   // trap counters idle while a reset runs, so one fault fires once
   assign pinTrapFire = !pinSelLegal && pinTrapCnt_ff == SOFT_LAST;
   assign thrTrapFire = !thrLegal && thrTrapCnt_ff == SOFT_LAST;
   assign lowFire = detectOn && lowSup && lowCnt_ff == LOW_LAST;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pinTrapCnt_ff <= '0;
      end else if (pinSelLegal || busy) begin
         pinTrapCnt_ff <= '0;
      end else if (pinTrapCnt_ff != SOFT_LAST) begin
         pinTrapCnt_ff <= pinTrapCnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         thrTrapCnt_ff <= '0;
      end else if (thrLegal || busy) begin
         thrTrapCnt_ff <= '0;
      end else if (thrTrapCnt_ff != SOFT_LAST) begin
         thrTrapCnt_ff <= thrTrapCnt_ff + 1'b1;
      end
   end

   // short dips restart the count, so they never reset
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lowCnt_ff <= '0;
      end else if (!detectOn || !lowSup || busy) begin
         lowCnt_ff <= '0;
      end else if (lowCnt_ff != LOW_LAST) begin
         lowCnt_ff <= lowCnt_ff + 1'b1;
      end
   end

   // ****************************************
   // reset sequencer
   // ****************************************
   rsc_pkg::rsc_state_type state_ff;
   rsc_pkg::rsc_state_type nxt_state;
   logic [CW-1:0] delayCnt_ff;
   logic pinHeld;
   logic softFire;

   // external pin only counts while selected
   assign pinHeld = extResetSel && !pinN;
   assign softFire = pinTrapFire || thrTrapFire || lowFire;
   assign busy = state_ff != rsc_pkg::ST_RUN;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         rsc_pkg::ST_RUN: begin
            if (pinHeld) begin
               nxt_state = rsc_pkg::ST_HOLD;
            end else if (softFire || watchdogRegTrap) begin
               nxt_state = rsc_pkg::ST_DELAY;
            end
         end
         rsc_pkg::ST_HOLD: begin
            if (pinN) begin
               nxt_state = rsc_pkg::ST_DELAY;
            end
         end
         rsc_pkg::ST_DELAY: begin
            // a pin pulled low again restarts the hold
            if (!pinN && extResetSel) begin
               nxt_state = rsc_pkg::ST_HOLD;
            end else if (delayCnt_ff == DELAY_LAST) begin
               nxt_state = rsc_pkg::ST_RUN;
            end
         end
         default: nxt_state = rsc_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= rsc_pkg::ST_DELAY;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         delayCnt_ff <= '0;
      end else if (state_ff != rsc_pkg::ST_DELAY) begin
         delayCnt_ff <= '0;
      end else if (delayCnt_ff != DELAY_LAST) begin
         delayCnt_ff <= delayCnt_ff + 1'b1;
      end
   end

   // core held in reset; ports float high as inputs meanwhile
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         coreReset_ff <= 1'b1;
      end else begin
         coreReset_ff <= nxt_state != rsc_pkg::ST_RUN;
      end
   end

   // ****************************************
   // register writes
   // ****************************************
   // write strobes decoded once, shared by the register processes
   logic wrPinSel;
   logic wrThreshold;
   logic wrFlags;
   assign wrPinSel = regWrStb && regAddr == rsc_pkg::ADDR_PIN_SELECT;
   assign wrThreshold = regWrStb && regAddr == rsc_pkg::ADDR_THRESHOLD;
   assign wrFlags = regWrStb && regAddr == rsc_pkg::ADDR_CAUSE_FLAGS;

   logic anyReset;
   assign anyReset = !busy &&
      (pinHeld || softFire || watchdogRegTrap);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pinSelect_ff <= rsc_pkg::PIN_SEL_POR;
      end else if (anyReset || watchdogWarmReset) begin
         // warm watchdog restart leaves the selection alone
         if (!watchdogWarmReset || anyReset) begin
            pinSelect_ff <= rsc_pkg::PIN_SEL_POR;
         end
      end else if (wrPinSel) begin
         pinSelect_ff <= regWrData;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         threshold_ff <= rsc_pkg::THR_POR;
      end else if (thrTrapFire && !busy) begin
         threshold_ff <= rsc_pkg::THR_POR;
      end else if (lowFire) begin
         threshold_ff <= threshold_ff;
      end else if (wrThreshold) begin
         threshold_ff <= regWrData;
      end
   end

   // set beats a same-cycle software clear
   logic [rsc_pkg::FLAG_BITS-1:0] flagSet;
   assign flagSet[rsc_pkg::FLAG_SELECT_REG] = pinTrapFire && !busy;
   assign flagSet[rsc_pkg::FLAG_LOW_SUPPLY] = lowFire && !busy;
   assign flagSet[rsc_pkg::FLAG_THRESHOLD_REG] = thrTrapFire && !busy;
   assign flagSet[rsc_pkg::FLAG_WATCHDOG_REG] = watchdogRegTrap && !busy;

   generate
      for (genvar i = 0; i < rsc_pkg::FLAG_BITS; i++) begin : g_flag
         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               flags_ff[i] <= 1'b0;
            end else if (flagSet[i]) begin
               flags_ff[i] <= 1'b1;
            end else if (wrFlags && !regWrData[i]) begin
               flags_ff[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // ****************************************
   // read port and status outputs
   // ****************************************
   logic [7:0] nxt_rdData;
   always_comb begin
      if (!regRdStb) begin
         nxt_rdData = 8'h00;
      end else if (regAddr == rsc_pkg::ADDR_PIN_SELECT) begin
         nxt_rdData = pinSelect_ff;
      end else if (regAddr == rsc_pkg::ADDR_CAUSE_FLAGS) begin
         nxt_rdData = {4'h0, flags_ff};
      end else if (regAddr == rsc_pkg::ADDR_THRESHOLD) begin
         nxt_rdData = threshold_ff;
      end else begin
         nxt_rdData = 8'h00;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         regRdData_ff <= 8'h00;
         pinIsReset_ff <= 1'b0;
         thresholdLevel_ff <= 3'h1;
         lowSupplyEnable_ff <= 1'b1;
      end else begin
         regRdData_ff <= nxt_rdData;
         pinIsReset_ff <= extResetSel;
         thresholdLevel_ff <= nxt_level;
         lowSupplyEnable_ff <= detectOn;
      end
   end
endmodule : rsc_reset_source_control

`default_nettype wire

// ---- bench/rsc_monitor.sv ----
// Purpose: port checks of reset source control
// Assumes: one clock domain, pins change just after edges
// Notes: bound to the design, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module rsc_monitor #(
   parameter int RESET_DELAY_CYCLES = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // register port
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [7:0] regRdData_ff,
   // pins and monitors
   input wire logic resetPinN,
   input wire logic lowSupply,
   input wire logic sleepOrIdle,
   input wire logic watchdogRegTrap,
   input wire logic watchdogWarmReset,
   // core side
   input wire logic coreReset_ff,
   input wire logic pinIsReset_ff,
   input wire logic [2:0] thresholdLevel_ff,
   input wire logic lowSupplyEnable_ff
);
   // ********
   // properties
   // ********
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // consecutive cycles with the core held in reset
   logic [15:0] holdCnt_ff;
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !coreReset_ff) begin
         holdCnt_ff <= 16'h0000;
      end else if (holdCnt_ff != 16'hFFFF) begin
         holdCnt_ff <= holdCnt_ff + 1'b1;
      end
   end
   // three low samples cover the two sync flops
   sequence seq_pin_low;
      !resetPinN [*3];
   endsequence
   sequence seq_short_dip;
      !lowSupply ##1 lowSupply [*2] ##1 !lowSupply;
   endsequence
   AST_POR_STATE: assert property (
      $fell(sys_rst) |-> thresholdLevel_ff == 3'h1 && !pinIsReset_ff)
      else $error("state after power-on wrong");
   AST_CORE_HOLD: assert property (
      $fell(sys_rst) |-> coreReset_ff [*4])
      else $error("core reset released early");
   AST_PIN_TAKE: assert property (
      pinIsReset_ff ##0 seq_pin_low |=> coreReset_ff)
      else $error("low pin did not reset");
   AST_PIN_REL: assert property (
      coreReset_ff && $rose(resetPinN) |-> coreReset_ff [*4])
      else $error("no delay after pin release");
   AST_LOW_FILTER: assert property (
      !coreReset_ff && lowSupplyEnable_ff ##0 seq_short_dip
      |=> !coreReset_ff [*4])
      else $error("short dip caused reset");
   AST_SLEEP_OFF: assert property (
      sleepOrIdle [*6] |-> !lowSupplyEnable_ff)
      else $error("detector on in sleep");
   AST_DISABLED: assert property (
      thresholdLevel_ff == 3'h0 [*2] |-> !lowSupplyEnable_ff)
      else $error("detector on while disabled");
   AST_SEL_EXT: assert property (
      regWrStb && regAddr == 2'h0 && regWrData == 8'hAA && !coreReset_ff
      |-> ##[1:3] pinIsReset_ff)
      else $error("pin not taken as reset");
   AST_FLAG_TOP: assert property (
      regRdStb && regAddr == 2'h1 |=> regRdData_ff[7:4] == 4'h0)
      else $error("flag upper bits not zero");
   AST_DELAY_MIN: assert property (
      $fell(coreReset_ff) |-> holdCnt_ff >= RESET_DELAY_CYCLES)
      else $error("core released before the delay");
endmodule : rsc_monitor
bind rsc_reset_source_control rsc_monitor #(
   .RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)
) u_rsc_monitor (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
   .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
   .regRdData_ff(regRdData_ff), .resetPinN(resetPinN),
   .lowSupply(lowSupply), .sleepOrIdle(sleepOrIdle),
   .watchdogRegTrap(watchdogRegTrap),
   .watchdogWarmReset(watchdogWarmReset),
   .coreReset_ff(coreReset_ff), .pinIsReset_ff(pinIsReset_ff),
   .thresholdLevel_ff(thresholdLevel_ff),
   .lowSupplyEnable_ff(lowSupplyEnable_ff)
);
`default_nettype wire

// ---- bench/rsc_far_side.sv ----
// Purpose: reset network and supply monitor model
// Assumes: pin has a pull-up, monitor idles not low
// Notes: driven by tasks called from the bench
`timescale 1ns/1ps
`default_nettype none
module rsc_far_side (
   // clock
   input wire logic clk_sys,
   // pin and supply
   output var logic resetPinN,
   output var logic lowSupply
);
   // ********
   // drive tasks
   // ********
   initial begin
      resetPinN = 1'b1;
      lowSupply = 1'b0;
   end
   // released pin returns to the pull-up level
   task automatic pull_pin(input int n);
      resetPinN <= 1'b0;
      repeat (n) @(posedge clk_sys);
      #1 resetPinN <= 1'b1;
   endtask : pull_pin
   task automatic dip(input int n);
      lowSupply <= 1'b1;
      repeat (n) @(posedge clk_sys);
      #1 lowSupply <= 1'b0;
   endtask : dip
endmodule : rsc_far_side
`default_nettype wire

// ---- bench/tb_top.sv ----
// Purpose: scenario bench for reset source control
// Assumes: short delay parameters keep the run brief
// Notes: all drive happens 1 ns after rising edges
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ********
   // signals and instances
   // ********
   localparam int SOFT = 6;
   localparam int DLY = 8;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [1:0] regAddr = 2'h0;
   logic [7:0] regWrData = 8'h00;
   logic regWrStb = 1'b0;
   logic regRdStb = 1'b0;
   logic sleepOrIdle = 1'b0;
   logic watchdogRegTrap = 1'b0;
   logic watchdogWarmReset = 1'b0;
   logic [7:0] regRdData_ff;
   logic resetPinN, lowSupply, coreReset_ff, pinIsReset_ff;
   logic lowSupplyEnable_ff;
   logic [2:0] thresholdLevel_ff;
   int fails = 0;
   int n_compared = 0;
   always #12.5 clk_sys = ~clk_sys;
   rsc_reset_source_control #(.SOFT_RESET_CYCLES(SOFT),
      .RESET_DELAY_CYCLES(DLY), .LOW_SUPPLY_CYCLES(5)
   ) u_rsc_reset_source_control (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData_ff(regRdData_ff), .resetPinN(resetPinN),
      .lowSupply(lowSupply), .sleepOrIdle(sleepOrIdle),
      .watchdogRegTrap(watchdogRegTrap),
      .watchdogWarmReset(watchdogWarmReset),
      .coreReset_ff(coreReset_ff), .pinIsReset_ff(pinIsReset_ff),
      .thresholdLevel_ff(thresholdLevel_ff),
      .lowSupplyEnable_ff(lowSupplyEnable_ff));
   rsc_far_side u_rsc_far_side (.clk_sys(clk_sys),
      .resetPinN(resetPinN), .lowSupply(lowSupply));
   // ********
   // shared tasks
   // ********
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // 1 ns past the edge keeps samples clear of updates
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      tick(1);
      regWrStb <= 1'b0;
      // idle edge keeps back-to-back strobes apart
      tick(1);
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      regAddr <= a;
      regRdStb <= 1'b1;
      tick(1);
      regRdStb <= 1'b0;
      chk(regRdData_ff, exp);
      tick(1);
   endtask : rd
   task automatic clr();
      wr(2'h1, 8'h00);
      rd(2'h1, 8'h00);
   endtask : clr
   task automatic set_sleep(input logic on);
      sleepOrIdle <= on;
   endtask : set_sleep
   task automatic wdog_pulse(input logic warm);
      {watchdogWarmReset, watchdogRegTrap} <= warm ? 2'b10 : 2'b01;
      tick(2);
      {watchdogWarmReset, watchdogRegTrap} <= 2'b00;
   endtask : wdog_pulse
   task automatic wait_rst(input logic lvl, output int n);
      for (n = 0; n < 200 && coreReset_ff !== lvl; n++) tick(1);
      if (n == 200) begin
         fails++;
         complete_run();
      end
   endtask : wait_rst
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run
   // ********
   // scenarios
   // ********
   task automatic t_codes();
      logic [7:0] code [6];
      int i;
      code = '{rsc_pkg::THR_1V7, rsc_pkg::THR_1V9, rsc_pkg::THR_2V55,
         rsc_pkg::THR_3V15, rsc_pkg::THR_3V8, rsc_pkg::THR_DISABLE};
      wr(2'h1, 8'hFF);
      rd(2'h1, 8'h00);
      for (i = 0; i < 6; i++) begin
         wr(2'h2, code[i]);
         tick(2);
         rd(2'h2, code[i]);
         chk(8'(thresholdLevel_ff), 8'((i + 1) % 6));
         chk(8'(lowSupplyEnable_ff), 8'(i < 5));
      end
   endtask : t_codes
   task automatic t_trap(input logic [1:0] a, input logic [7:0] bad,
      input int b);
      int n;
      wr(a, bad);
      wait_rst(1'b1, n);
      chk(8'(n >= SOFT - 1), 8'h01);
      wait_rst(1'b0, n);
      chk(8'(n >= DLY), 8'h01);
      rd(2'h1, 8'(1 << b));
      rd(a, a == 2'h0 ? rsc_pkg::PIN_SEL_POR : rsc_pkg::THR_POR);
      clr();
   endtask : t_trap
   task automatic t_low();
      int n;
      wr(2'h2, rsc_pkg::THR_2V55);
      tick(4);
      u_rsc_far_side.dip(2);
      tick(8);
      chk(8'(coreReset_ff), 8'h00);
      u_rsc_far_side.dip(4);
      tick(8);
      chk(8'(coreReset_ff), 8'h00);
      u_rsc_far_side.dip(12);
      wait_rst(1'b1, n);
      wait_rst(1'b0, n);
      rd(2'h1, 8'h04);
      rd(2'h2, rsc_pkg::THR_2V55);
      clr();
      set_sleep(1'b1);
      tick(8);
      chk(8'(lowSupplyEnable_ff), 8'h00);
      u_rsc_far_side.dip(12);
      tick(4);
      chk(8'(coreReset_ff), 8'h00);
      set_sleep(1'b0);
      tick(8);
      chk(8'(lowSupplyEnable_ff), 8'h01);
   endtask : t_low
   task automatic t_pin();
      int n;
      u_rsc_far_side.pull_pin(6);
      tick(2);
      chk(8'(coreReset_ff), 8'h00);
      wr(2'h0, rsc_pkg::PIN_SEL_EXT_RESET);
      tick(2);
      chk(8'(pinIsReset_ff), 8'h01);
      u_rsc_far_side.pull_pin(20);
      chk(8'(coreReset_ff), 8'h01);
      wait_rst(1'b0, n);
      chk(8'(n >= DLY), 8'h01);
      rd(2'h0, rsc_pkg::PIN_SEL_POR);
      chk(8'(pinIsReset_ff), 8'h00);
   endtask : t_pin
   task automatic t_wdog();
      int n;
      wdog_pulse(1'b0);
      wait_rst(1'b1, n);
      wait_rst(1'b0, n);
      rd(2'h1, 8'h01);
      clr();
      wr(2'h0, rsc_pkg::PIN_SEL_EXT_RESET);
      wdog_pulse(1'b1);
      tick(4);
      wait_rst(1'b0, n);
      rd(2'h0, rsc_pkg::PIN_SEL_EXT_RESET);
   endtask : t_wdog
   initial begin
      int n;
      tick(10);
      sys_rst <= 1'b0;
      rd(2'h0, rsc_pkg::PIN_SEL_POR);
      chk(8'(coreReset_ff), 8'h01);
      rd(2'h2, rsc_pkg::THR_POR);
      rd(2'h1, 8'h00);
      rd(2'h3, 8'h00);
      wait_rst(1'b0, n);
      t_codes();
      t_trap(2'h0, 8'h12, 3);
      t_trap(2'h2, 8'h00, 1);
      t_low();
      t_pin();
      t_wdog();
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
